// ### hw/fcl_consts.vh
// Constants for the configuration load port
`ifndef FCL_CONSTS_VH
`define FCL_CONSTS_VH

`define FCL_CLK_NS 40
`define FCL_REQ_FALL_NS 600
`define FCL_REQ_FALL_CYC ((`FCL_REQ_FALL_NS) / (`FCL_CLK_NS))
`define FCL_REQ_MIN_US 2
`define FCL_REQ_MIN_CYC (((`FCL_REQ_MIN_US) * 1000 + (`FCL_CLK_NS) - 1) / (`FCL_CLK_NS))
`define FCL_STAT_MIN_US 268
`define FCL_STAT_MAX_US 1506
`define FCL_STAT_MIN_CYC (((`FCL_STAT_MIN_US) * 1000 + (`FCL_CLK_NS) - 1) / (`FCL_CLK_NS))
`define FCL_STAT_MAX_CYC (((`FCL_STAT_MAX_US) * 1000) / (`FCL_CLK_NS))
`define FCL_INIT_CYCLES 17408
`define FCL_USR_DELAY_EDGES 4
`define FCL_TRAIL_EDGES 2
`define FCL_RATE_12M5 2'h0
`define FCL_RATE_25M 2'h1
`define FCL_RATE_50M 2'h2
`define FCL_RATE_100M 2'h3

`endif

// ### hw/fcl_config_port.v
// Configuration load port: parallel and active serial load, status and init
`timescale 1ns/1ps
// Function
// - User mode all high; request low restarts
// - Status held low during power-on delay
// - Load-complete low until all data received
// - Stopped parallel clock simply pauses loading
// - Load-complete rises only after full image
// - Init-done output low until init finishes
// - Request low drops done, status within 600ns
// - Status low pulse 268 to 1506 us
// - Status rises within 1506 us of request
// - Initialization takes 17408 init clock cycles
// - User clock used after four clock periods
// - Oscillator init finishes within 175-437 us; here 17408 ticks of two 40 ns clocks take about 1393 us
// - x4 serial mode takes four bits per cycle
// - Serial command out on fall, sample fall
// - Serial clock rate selectable among four
// - Chained serial load forbids fastest rate
// - Remote update limits serial rate to slowest
// - Init clock from oscillator or user clock
// - Data ratio from width and features
`include "fcl_consts.vh"

// Design notes
// Request, host clock, user clock and status pin inputs pass two flip-flops; data pins are sampled directly.
// Parallel words are taken on the synchronised rising edge of the host
// clock, so the host clock must stay well below the system clock.
// A stopped host clock leaves the sequencer waiting in the load state.
// The status pin is open drain: the block only ever drives it low.
// Another party holding status low delays the start of loading.
// Status seen low during loading marks a load error until restart.
// The serial clock comes from a divider of the system clock; with the 40 ns
// system clock every rate setting runs at one eighth of its named rate.
// Initialisation counts ticks of either the oscillator divider or the
// synchronised user clock; the user clock must be slow enough for the
// synchroniser to see every rising edge.
// A low clock enable freezes every register, synchronisers included.

module fcl_config_port #(
  parameter IMAGE_WORDS = 1024,
  parameter INIT_CYCLES = `FCL_INIT_CYCLES,
  parameter STAT_MIN_CYC = `FCL_STAT_MIN_CYC,
  parameter POR_CYCLES = 8192,
  parameter OSC_DIV = 2
) (
  input wire clk,
  input wire sys_rst,
  input wire clkEn,
  input wire cfgRequestN,
  input wire statusIn,
  output wire statusOut,
  output wire statusOe,
  output reg loadDone,
  output reg initDoneN,
  output reg userMode,
  output reg cfgError,
  input wire activeSerialMode,
  input wire wide16,
  input wire compressOn,
  input wire encryptOn,
  input wire serialX4,
  input wire chainMode,
  input wire remoteUpdate,
  input wire [1:0] rateSel,
  input wire useUserClock,
  input wire initDoneEnable,
  input wire cfgClockIn,
  input wire [15:0] dataIn,
  input wire userInitClock,
  output reg cfgClockOut,
  output reg cfgClockOe,
  output reg bootRomCs,
  output reg bootRomIo,
  output reg [31:0] wordCount,
  output reg [15:0] lastWord
);
  localparam ST_POR = 3'h0;
  localparam ST_RESET = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_LOAD = 3'h3;
  localparam ST_TRAIL = 3'h4;
  localparam ST_INIT = 3'h5;
  localparam ST_USER = 3'h6;

  reg [2:0] state_reg;
  reg [23:0] timer_reg;
  reg [15:0] assemble_reg;
  reg [4:0] nibble_reg;
  reg [2:0] ratioCnt_reg;
  reg [2:0] edgeCnt_reg;
  reg [7:0] divCnt_reg;
  reg [2:0] reqMeta_reg, clkMeta_reg, usrMeta_reg, statMeta_reg;
  reg statusLow_reg;
  // Serial read command shifted out ahead of the data stream
  localparam READ_CMD = 8'h03;
  reg [7:0] cmd_reg;
  reg [3:0] cmdBits_reg;

  wire reqSync = reqMeta_reg[1];
  wire cfg_clock = clkMeta_reg[1];
  wire dclkRise = clkMeta_reg[1] & ~clkMeta_reg[2];
  wire dclkFall = ~clkMeta_reg[1] & clkMeta_reg[2];
  wire usrRise = usrMeta_reg[1] & ~usrMeta_reg[2];
  wire statExt = statMeta_reg[1];

  // Data ratio from width and features
  reg [2:0] ratio;
  always @* begin
    if (wide16) begin
      if (compressOn)
        ratio = 3'h4;
      else if (encryptOn)
        ratio = 3'h2;
      else
        ratio = 3'h1;
    end else begin
      ratio = compressOn ? 3'h2 : 3'h1;
    end
  end

  // Effective serial rate: clamp for chain and remote update
  reg [1:0] rateEff;
  always @* begin
    if (remoteUpdate)
      rateEff = `FCL_RATE_12M5;
    else if (chainMode && rateSel == `FCL_RATE_100M)
      rateEff = `FCL_RATE_50M;
    else
      rateEff = rateSel;
  end

  // Half period in system clocks for each rate setting
  reg [7:0] halfPeriod;
  always @* begin
    case (rateEff)
      `FCL_RATE_12M5: halfPeriod = 8'h08;
      `FCL_RATE_25M: halfPeriod = 8'h04;
      `FCL_RATE_50M: halfPeriod = 8'h02;
      default: halfPeriod = 8'h01;
    endcase
  end

  // Open-drain status: drive low while statusLow_reg
  assign statusOut = 1'b0;
  assign statusOe = statusLow_reg;

  // Input synchronisers
  always @(posedge clk) begin
    if (sys_rst) begin
      reqMeta_reg <= 3'h7;
      clkMeta_reg <= 3'h0;
      usrMeta_reg <= 3'h0;
      statMeta_reg <= 3'h0;
    end else if (clkEn) begin
      reqMeta_reg <= {reqMeta_reg[1:0], cfgRequestN};
      clkMeta_reg <= {clkMeta_reg[1:0], cfgClockIn};
      usrMeta_reg <= {usrMeta_reg[1:0], userInitClock};
      statMeta_reg <= {statMeta_reg[1:0], statusIn};
    end
  end

  // Serial word from x1 or x4 bits
  wire [15:0] serialNext = serialX4 ? {assemble_reg[11:0], dataIn[3:0]}
                                    : {assemble_reg[14:0], dataIn[0]};
  wire [4:0] serialStep = serialX4 ? 5'h4 : 5'h1;
  wire serialFall = cfgClockOut && (divCnt_reg == halfPeriod - 8'h01);
  wire [15:0] wordIn = wide16 ? dataIn : {8'h00, dataIn[7:0]};
  wire initTick = useUserClock ? usrRise : (divCnt_reg == 8'h00);

  // Main sequencer
  always @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_POR;
      timer_reg <= 24'h0;
      statusLow_reg <= 1'b1;
      loadDone <= 1'b0;
      initDoneN <= 1'b1;
      userMode <= 1'b0;
      cfgError <= 1'b0;
      cfgClockOut <= 1'b0;
      cfgClockOe <= 1'b0;
      bootRomCs <= 1'b1;
      bootRomIo <= 1'b0;
      wordCount <= 32'h0;
      lastWord <= 16'h0;
      assemble_reg <= 16'h0;
      nibble_reg <= 5'h0;
      ratioCnt_reg <= 3'h0;
      edgeCnt_reg <= 3'h0;
      divCnt_reg <= 8'h0;
      cmd_reg <= 8'h00;
      cmdBits_reg <= 4'h0;
    end else if (clkEn) begin
      if (!reqSync && state_reg != ST_POR && state_reg != ST_RESET) begin
        state_reg <= ST_RESET;
        statusLow_reg <= 1'b1;
        loadDone <= 1'b0;
        userMode <= 1'b0;
        initDoneN <= 1'b1;
        cfgClockOe <= 1'b0;
        bootRomCs <= 1'b1;
        timer_reg <= 24'h0;
      end else begin
        case (state_reg)
          ST_POR: begin
            statusLow_reg <= 1'b1;
            loadDone <= 1'b0;
            timer_reg <= timer_reg + 24'h1;
            if (timer_reg >= POR_CYCLES - 1) begin
              state_reg <= ST_RESET;
              timer_reg <= 24'h0;
            end
          end
          ST_RESET: begin
            statusLow_reg <= 1'b1;
            if (timer_reg < 24'hffffff)
              timer_reg <= timer_reg + 24'h1;
            // Release once request high and minimum pulse elapsed
            if (reqSync && timer_reg >= STAT_MIN_CYC - 1) begin
              statusLow_reg <= 1'b0;
              state_reg <= ST_WAIT;
              cfgError <= 1'b0;
              wordCount <= 32'h0;
              ratioCnt_reg <= 3'h0;
              nibble_reg <= 5'h0;
              divCnt_reg <= 8'h0;
              // Command is reloaded for every new load
              cmd_reg <= READ_CMD;
              cmdBits_reg <= 4'h8;
            end
          end
          ST_WAIT: begin
            // Held low by another party extends the wait
            if (statExt)
              state_reg <= ST_LOAD;
          end
          ST_LOAD: begin
            if (!statExt)
              cfgError <= 1'b1;
            if (!activeSerialMode) begin
              // Parallel: only clock edges advance; stopped clock waits
              if (dclkRise) begin
                if (ratioCnt_reg == 3'h0) begin
                  lastWord <= wordIn;
                  wordCount <= wordCount + 32'h1;
                end
                ratioCnt_reg <= (ratioCnt_reg == ratio - 3'h1) ? 3'h0 : ratioCnt_reg + 3'h1;
              end
            end else begin
              cfgClockOe <= 1'b1;
              bootRomCs <= 1'b0;
              // Serial clock divider: one toggle per half period
              if (divCnt_reg == halfPeriod - 8'h01) begin
                divCnt_reg <= 8'h0;
                cfgClockOut <= ~cfgClockOut;
              end else begin
                divCnt_reg <= divCnt_reg + 8'h01;
              end
              // Falling edge: next command bit out, flash data in
              if (serialFall) begin
                if (cmdBits_reg != 4'h0) begin
                  bootRomIo <= cmd_reg[7];
                  cmd_reg <= {cmd_reg[6:0], 1'b0};
                  cmdBits_reg <= cmdBits_reg - 4'h1;
                end else begin
                  // Command done: line rests low, data assembled MSB first
                  bootRomIo <= 1'b0;
                  assemble_reg <= serialNext;
                  if (nibble_reg + serialStep >= 5'h10) begin
                    nibble_reg <= 5'h0;
                    lastWord <= serialNext;
                    wordCount <= wordCount + 32'h1;
                  end else begin
                    nibble_reg <= nibble_reg + serialStep;
                  end
                end
              end
            end
            if (wordCount >= IMAGE_WORDS && ratioCnt_reg == 3'h0 && !cfgError) begin
              loadDone <= 1'b1;
              state_reg <= ST_TRAIL;
              edgeCnt_reg <= 3'h0;
              initDoneN <= ~initDoneEnable;
            end
          end
          ST_TRAIL: begin
            // Count trailing falling edges, then user clock settle
            if (activeSerialMode ? serialFall : dclkFall)
              edgeCnt_reg <= edgeCnt_reg + 3'h1;
            // Serial clock keeps its selected rate for trailing edges
            if (activeSerialMode) begin
              if (divCnt_reg == halfPeriod - 8'h01) begin
                divCnt_reg <= 8'h0;
                cfgClockOut <= ~cfgClockOut;
              end else begin
                divCnt_reg <= divCnt_reg + 8'h01;
              end
            end
            if (edgeCnt_reg >= (useUserClock ? `FCL_USR_DELAY_EDGES : `FCL_TRAIL_EDGES)) begin
              state_reg <= ST_INIT;
              timer_reg <= 24'h0;
              divCnt_reg <= 8'h0;
              cfgClockOe <= 1'b0;
              bootRomCs <= 1'b1;
            end
          end
          ST_INIT: begin
            divCnt_reg <= (divCnt_reg == OSC_DIV - 1) ? 8'h0 : divCnt_reg + 8'h01;
            if (initTick)
              timer_reg <= timer_reg + 24'h1;
            if (timer_reg >= INIT_CYCLES) begin
              state_reg <= ST_USER;
              userMode <= 1'b1;
              initDoneN <= 1'b1;
            end
          end
          ST_USER: begin
            userMode <= 1'b1;
          end
          default: state_reg <= ST_RESET;
        endcase
      end
    end
  end
endmodule

// ### sim/fcl_port_asserts.sv
// Checker for the configuration load port
`timescale 1ns/1ps
module fcl_port_asserts #(
  parameter IMAGE_WORDS = 4,
  parameter INIT_CYCLES = 16,
  parameter STAT_MIN_CYC = 20
) (
  input wire clk,
  input wire sys_rst,
  input wire cfgRequestN,
  input wire cfgClockIn,
  input wire statusOe,
  input wire loadDone,
  input wire initDoneN,
  input wire userMode,
  input wire initDoneEnable,
  input wire [31:0] wordCount
);
  reg [31:0] lowCnt;
  reg [31:0] initCnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Length of status low and of init
  always @(posedge clk) begin
    lowCnt <= (sys_rst || !statusOe) ? 32'h0 : lowCnt + 32'h1;
    initCnt <= (loadDone && !userMode) ? initCnt + 32'h1 : 32'h0;
  end
  a_req_drops_done: assert property ($fell(cfgRequestN) |-> ##[1:15] (statusOe && !loadDone))
    else $error("request fall not seen");
  a_status_min: assert property ($fell(statusOe) |-> lowCnt >= STAT_MIN_CYC)
    else $error("status low too short");
  a_status_release: assert property ($rose(cfgRequestN) |-> ##[1:40] !statusOe)
    else $error("status not released");
  a_done_words: assert property ($rose(loadDone) |-> wordCount == IMAGE_WORDS)
    else $error("done before full image");
  a_user_high: assert property ($rose(userMode) |-> loadDone && initDoneN && !statusOe)
    else $error("user mode flags wrong");
  a_init_length: assert property ($rose(userMode) |-> initCnt >= INIT_CYCLES)
    else $error("init too short");
  a_init_low: assert property ($rose(userMode) && initDoneEnable |-> !$past(initDoneN))
    else $error("init done not low");
  a_pause_hold: assert property (($stable(cfgClockIn) && cfgRequestN)[*6] |->
    !(wordCount > $past(wordCount)))
    else $error("word taken while paused");
endmodule
bind fcl_config_port fcl_port_asserts #(.IMAGE_WORDS(IMAGE_WORDS), .INIT_CYCLES(INIT_CYCLES),
  .STAT_MIN_CYC(STAT_MIN_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst), .cfgRequestN(cfgRequestN),
  .cfgClockIn(cfgClockIn), .statusOe(statusOe), .loadDone(loadDone), .initDoneN(initDoneN),
  .userMode(userMode), .initDoneEnable(initDoneEnable), .wordCount(wordCount));

// ### sim/fcl_host_model.sv
// Parallel load host driving clock and data words
`timescale 1ns/1ps
module fcl_host_model (
  output logic cfgClock,
  output logic [15:0] data
);
  // Clock rests low outside frames
  initial begin
    cfgClock = 1'b0;
    data = 16'h0;
  end
  // Word set up first, held over ratio periods of 320 ns
  task automatic send(input logic [15:0] w, input int r);
    data = w;
    #80;
    repeat (r) begin
      cfgClock = 1'b1;
      #160;
      cfgClock = 1'b0;
      #160;
    end
    data = ~w;
  endtask
  // Trailing clocks after the load flag
  task automatic trail(input int n);
    repeat (n) begin
      #160;
      cfgClock = 1'b1;
      #160;
      cfgClock = 1'b0;
    end
  endtask
endmodule

// ### sim/fcl_config_port_test.sv
// Self-checking bench for the configuration load port
`timescale 1ns/1ps
module fcl_config_port_test;
  localparam int WORDS = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfgRequestN = 1'b1;
  logic wide16 = 1'b0;
  logic compressOn = 1'b0;
  logic encryptOn = 1'b0;
  logic useUserClock = 1'b0;
  logic initDoneEnable = 1'b0;
  logic userInitClock = 1'b0;
  logic chainMode = 1'b0;
  logic [1:0] rateSel = 2'h0;
  logic clkEn = 1'b1;
  logic activeSerialMode = 1'b0;
  logic serialX4 = 1'b0;
  logic remoteUpdate = 1'b0;
  logic extLow = 1'b0;
  wire statusOe, loadDone, initDoneN, userMode, cfgClockIn, cfgError;
  wire [31:0] wordCount;
  wire [15:0] lastWord, dataIn;
  wire statusIn = ~statusOe & ~extLow;
  int n_mismatch = 0;
  int n_checks = 0;
  fcl_config_port #(.IMAGE_WORDS(WORDS), .INIT_CYCLES(16), .STAT_MIN_CYC(20), .POR_CYCLES(10),
    .OSC_DIV(2)) i_dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .cfgRequestN(cfgRequestN),
    .statusIn(statusIn), .statusOut(), .statusOe(statusOe), .loadDone(loadDone),
    .initDoneN(initDoneN), .userMode(userMode), .cfgError(cfgError),
    .activeSerialMode(activeSerialMode), .wide16(wide16), .compressOn(compressOn),
    .encryptOn(encryptOn), .serialX4(serialX4), .chainMode(chainMode),
    .remoteUpdate(remoteUpdate), .rateSel(rateSel), .useUserClock(useUserClock),
    .initDoneEnable(initDoneEnable), .cfgClockIn(cfgClockIn), .dataIn(dataIn),
    .userInitClock(userInitClock), .cfgClockOut(), .cfgClockOe(), .bootRomCs(), .bootRomIo(),
    .wordCount(wordCount), .lastWord(lastWord));
  fcl_host_model i_host (.cfgClock(cfgClockIn), .data(dataIn));
  // Clock and free-running user init clock
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) userInitClock <= ~userInitClock;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  // One full load per width and feature mix
  initial begin
    int k;
    logic [15:0] w;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(statusOe), 1);
    chk(32'(loadDone), 0);
    for (int m = 0; m < 4; m++) begin
      int r;
      r = (m[1] ? 2 : 1) * (m[0] ? 2 : 1);
      @(posedge clk);
      wide16 <= m[1];
      compressOn <= m[0];
      encryptOn <= !m[0];
      useUserClock <= m[0];
      initDoneEnable <= !m[0];
      chainMode <= m[1];
      rateSel <= 2'(m);
      cfgRequestN <= 1'b0;
      repeat (60) @(posedge clk);
      chk(32'(statusOe), 1);
      chk(32'(loadDone), 0);
      cfgRequestN <= 1'b1;
      for (k = 0; k < 2000 && !statusIn; k++) @(posedge clk);
      chk(32'(statusIn), 1);
      repeat (50) @(posedge clk);
      for (k = 0; k < WORDS; k++) begin
        w = 16'ha5c0 + 16'(k);
        chk(32'(loadDone), 0);
        i_host.send(w, r);
        if (k == 1) begin
          repeat (30) @(posedge clk);
          chk(wordCount, 2);
        end
      end
      repeat (4) @(posedge clk);
      chk(wordCount, WORDS);
      chk(32'(lastWord), m[1] ? 32'(w) : 32'(w[7:0]));
      chk(32'(loadDone), 1);
      repeat (40) @(posedge clk);
      chk(32'(userMode), 0);
      i_host.trail(m[0] ? 4 : 2);
      for (k = 0; k < 3000 && !userMode; k++) @(posedge clk);
      chk(32'(userMode), 1);
      chk(32'(initDoneN), 1);
      chk(32'(statusOe), 0);
    end
    // Status pulled low mid-load, frozen clock enable, then restart
    @(posedge clk);
    cfgRequestN <= 1'b0;
    repeat (60) @(posedge clk);
    cfgRequestN <= 1'b1;
    for (k = 0; k < 2000 && !statusIn; k++) @(posedge clk);
    repeat (50) @(posedge clk);
    i_host.send(16'h1234, 4);
    @(posedge clk);
    extLow <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(cfgError), 1);
    clkEn <= 1'b0;
    extLow <= 1'b0;
    cfgRequestN <= 1'b0;
    repeat (6) @(posedge clk);
    chk(32'(statusOe), 0);
    clkEn <= 1'b1;
    repeat (60) @(posedge clk);
    chk(32'(statusOe), 1);
    cfgRequestN <= 1'b1;
    for (k = 0; k < 2000 && !statusIn; k++) @(posedge clk);
    chk(32'(statusIn), 1);
    chk(32'(cfgError), 0);
    final_report();
  end
endmodule
